// ===== core/mch_uart_consts.svh
// register offsets, field positions and reset values of the extended serial configuration block
// How it works
// - rx size field gives 5..17 data bits
// - rx code 1110 takes 16 or 17, Manchester only
// - bit 4 selects extended mode, else standard
// - rx stop select: 0 one, 1 two
// - tx stop bits follow standard stop setting
// - bit 1 selects Manchester, else level coding
// - extended off: standard async/sync, up to 9
// - extended on: 17 bits, sync Manchester reserved
// - bit 0 selects MSB first, else LSB
// - status bit 3 flags Manchester framing error
// - status bit 2 tells 16 or 17 bits
// - status bits 1:0 hold Manchester stop bits
// - Manchester bit counter limit is 16 bits
// - tx size field uses same code set except 1110, which is rejected
// - extended ninth bit sits in extension bit 0
`ifndef MCH_UART_CONSTS_SVH
`define MCH_UART_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define A_CHAR_SIZE 5'h00
`define A_EXT_CTRL 5'h04
`define A_MCH_STAT 5'h08
`define A_BAUD_LOW 5'h0C
`define A_BAUD_HIGH 5'h10
`define A_STD_CTRL 5'h14
`define A_RX_DATA 5'h18

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RST_CHAR_SIZE 8'h33
`define RST_ZERO8 8'h00
`define EXT_CTRL_MASK 8'h1B
`define F_EXT_EN 4
`define F_RX_STOP 3
`define F_MCH 1
`define F_MSB 0
`define F_FEM 3
`define F_F17 2
`define F_SYNC 0
`define F_TX_STOP 1
`define F_STD_SIZE_HI 7
`define F_STD_SIZE_LO 5
`define F_PAR_HI 4
`define F_PAR_LO 3
`define CODE_16_OR_17 4'hE
`define CODE_9BIT 4'h7
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== core/mch_uart_pkg.sv
// types shared by the extended serial configuration block
package mch_uart_pkg;

    typedef enum logic [5:0] {
        MODE_STD_ASYNC = 6'b00_0001,
        MODE_STD_SYNC = 6'b00_0010,
        MODE_EXT_ASYNC_LVL = 6'b00_0100,
        MODE_EXT_ASYNC_MCH = 6'b00_1000,
        MODE_EXT_SYNC_LVL = 6'b01_0000,
        MODE_RESERVED = 6'b10_0000
    } op_mode_e;

    typedef struct packed {
        op_mode_e mode;
        logic [4:0] rx_bits;
        logic rx_accept_16;
        logic [4:0] tx_bits;
        logic rx_two_stop;
        logic tx_two_stop;
        logic msb_first;
        logic manchester;
        logic [1:0] parity_sel;
        logic size_ok;
    } frame_cfg_s;

    typedef struct packed {
        logic done;
        logic mch_frame_err;
        logic len_17;
        logic [1:0] stop_vals;
        logic [16:0] data;
    } rx_evt_s;

endpackage

// ===== core/mch_uart_cfg.sv
// AXI4-Lite register file, mode decode and Manchester bit timer
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "mch_uart_consts.svh"

module mch_uart_cfg
    import mch_uart_pkg::*;
#(
    parameter int BAUD_W = 16
)
(
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [4:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [4:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire rx_evt_s rx_evt, // receiver frame complete and its data
    input wire logic mch_rx_busy, // Manchester reception in progress
    output frame_cfg_s frame_cfg, // frame setup for the data path
    output logic mch_bit_tick, // Manchester bit period elapsed
    output logic rx_buf_read // pulse: receive data word was read
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] size_bits(input logic [3:0] code);
        logic [4:0] n;
        n = 5'd0;
        unique case (code)
            4'h0: n = 5'd5;
            4'h1: n = 5'd6;
            4'h2: n = 5'd7;
            4'h3: n = 5'd8;
            4'h7: n = 5'd9;
            4'h8: n = 5'd13;
            4'h9: n = 5'd14;
            4'hA: n = 5'd15;
            4'hB: n = 5'd16;
            4'hE: n = 5'd17;
            4'hF: n = 5'd17;
            default: n = 5'd0;
        endcase
        return n;
    endfunction

    function automatic logic [2:0] std_code(input logic [3:0] code);
        logic [2:0] c;
        c = code[2:0];
        return c;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] char_size_q;
    logic [7:0] ext_ctrl_q;
    logic [7:0] std_ctrl_q;
    logic [BAUD_W-1:0] baud_limit_q;
    logic fem_q;
    logic f17_q;
    logic [1:0] stop_vals_q;
    logic [16:0] rx_data_q;
    logic [BAUD_W-1:0] bit_cnt_q;
    logic [4:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_lane_q;
    logic aw_have_q;
    logic w_have_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic ext_en;
    logic mch_on;
    logic wr_fire;
    logic rd_fire;
    logic wr_ok;
    logic rd_ok;
    logic [3:0] std_size;
    op_mode_e mode_d;
    logic [7:0] rd_byte;
    logic [31:0] rd_word;
    frame_cfg_s cfg_d;

    // ----------------------------------------------------------------
    // mode and frame decode
    // ----------------------------------------------------------------
    assign ext_en = ext_ctrl_q[`F_EXT_EN];
    assign mch_on = ext_en & ext_ctrl_q[`F_MCH];

    always_comb
    begin
        mode_d = MODE_STD_ASYNC;
        unique case ({ext_en, std_ctrl_q[`F_SYNC], ext_ctrl_q[`F_MCH]})
            3'b000, 3'b001: mode_d = MODE_STD_ASYNC;
            3'b010, 3'b011: mode_d = MODE_STD_SYNC;
            3'b100: mode_d = MODE_EXT_ASYNC_LVL;
            3'b101: mode_d = MODE_EXT_ASYNC_MCH;
            3'b110: mode_d = MODE_EXT_SYNC_LVL;
            3'b111: mode_d = MODE_RESERVED;
        endcase
    end

    // standard mode takes its size from the standard 3-bit field
    assign std_size = {1'b0, std_ctrl_q[`F_STD_SIZE_HI:`F_STD_SIZE_LO]};

    always_comb
    begin
        cfg_d.mode = mode_d;
        cfg_d.tx_two_stop = std_ctrl_q[`F_TX_STOP];
        cfg_d.parity_sel = std_ctrl_q[`F_PAR_HI:`F_PAR_LO];
        cfg_d.manchester = mch_on;
        if (ext_en)
        begin
            cfg_d.rx_bits = size_bits(char_size_q[3:0]);
            cfg_d.tx_bits = size_bits(char_size_q[7:4]);
            cfg_d.rx_accept_16 = (char_size_q[3:0] == `CODE_16_OR_17);
            cfg_d.rx_two_stop = ext_ctrl_q[`F_RX_STOP];
            cfg_d.msb_first = ext_ctrl_q[`F_MSB];
            // 16-or-17 code only valid with Manchester
            cfg_d.size_ok = (cfg_d.rx_bits != 5'd0)
                && (cfg_d.tx_bits != 5'd0)
                && (char_size_q[7:4] != `CODE_16_OR_17)
                && (!cfg_d.rx_accept_16 || mch_on)
                && (mode_d != MODE_RESERVED);
        end
        else
        begin
            // plain UART, at most 9 bits, LSB first
            cfg_d.rx_bits = size_bits(std_size);
            cfg_d.tx_bits = cfg_d.rx_bits;
            cfg_d.rx_accept_16 = 1'b0;
            cfg_d.rx_two_stop = std_ctrl_q[`F_TX_STOP];
            cfg_d.msb_first = 1'b0;
            cfg_d.size_ok = (size_bits(std_size) != 5'd0)
                && (std_code(std_size) <= 3'd3 || std_size == `CODE_9BIT);
        end
    end

    // data output from flip-flops; status capture uses the live decode
    always_ff @(posedge aclk)
    begin
        frame_cfg <= cfg_d;
    end

    // ----------------------------------------------------------------
    // Manchester receive bit timer
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !mch_rx_busy || !mch_on)
            bit_cnt_q <= '0;
        else if (bit_cnt_q >= baud_limit_q)
            bit_cnt_q <= '0;
        else
            bit_cnt_q <= bit_cnt_q + {{(BAUD_W-1){1'b0}}, 1'b1};
    end

    assign mch_bit_tick = mch_rx_busy & mch_on & (bit_cnt_q >= baud_limit_q);

    // ----------------------------------------------------------------
    // receive status and data capture
    // ----------------------------------------------------------------
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign rx_buf_read = rd_fire && (s_axi_araddr == `A_RX_DATA);

    // flags live from frame complete until the data word is read; set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fem_q <= 1'b0;
        else if (rx_evt.done && mch_on)
            fem_q <= rx_evt.mch_frame_err;
        else if (rx_buf_read)
            fem_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            f17_q <= 1'b0;
        else if (rx_evt.done && mch_on && cfg_d.rx_accept_16)
            f17_q <= rx_evt.len_17;
        else if (rx_buf_read)
            f17_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stop_vals_q <= 2'b00;
        else if (rx_evt.done && mch_on)
            stop_vals_q <= rx_evt.stop_vals;
    end

    // extended 9-bit frames carry bit 8 in extension bit 0, standard ones in bit 16
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_data_q <= 17'h0_0000;
        else if (rx_evt.done && !ext_en && cfg_d.rx_bits == 5'd9)
            rx_data_q <= {rx_evt.data[8], 8'h00, rx_evt.data[7:0]};
        else if (rx_evt.done)
            rx_data_q <= rx_evt.data;
    end

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_ok = (wr_addr_q <= `A_RX_DATA) && (wr_addr_q[1:0] == 2'b00);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            wr_addr_q <= 5'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q <= 1'b1;
            wr_addr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_have_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_q <= 1'b0;
            wr_data_q <= 8'h00;
            wr_lane_q <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q <= 1'b1;
            wr_data_q <= s_axi_wdata[7:0];
            wr_lane_q <= s_axi_wstrb[0];
        end
        else if (wr_fire)
            w_have_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ----------------------------------------------------------------
    // register writes; status bits and data word are read only
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            char_size_q <= `RST_CHAR_SIZE;
            ext_ctrl_q <= `RST_ZERO8;
            std_ctrl_q <= `RST_ZERO8;
            baud_limit_q <= '0;
        end
        else if (wr_fire && wr_lane_q)
        begin
            unique case (wr_addr_q)
                `A_CHAR_SIZE: char_size_q <= wr_data_q;
                `A_EXT_CTRL: ext_ctrl_q <= wr_data_q & `EXT_CTRL_MASK;
                `A_BAUD_LOW: baud_limit_q[7:0] <= wr_data_q;
                `A_BAUD_HIGH: baud_limit_q[15:8] <= wr_data_q;
                `A_STD_CTRL: std_ctrl_q <= wr_data_q;
                default: ; // status: data and unmapped: no effect
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign rd_ok = (s_axi_araddr <= `A_RX_DATA) && (s_axi_araddr[1:0] == 2'b00);

    always_comb
    begin
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            `A_CHAR_SIZE: rd_byte = char_size_q;
            `A_EXT_CTRL: rd_byte = ext_ctrl_q;
            `A_MCH_STAT: rd_byte = {4'h0, fem_q, f17_q, stop_vals_q};
            `A_BAUD_LOW: rd_byte = baud_limit_q[7:0];
            `A_BAUD_HIGH: rd_byte = baud_limit_q[15:8];
            `A_STD_CTRL: rd_byte = std_ctrl_q;
            default: rd_byte = 8'h00;
        endcase
        rd_word = (s_axi_araddr == `A_RX_DATA) ? {15'h0000, rx_data_q}
            : {24'h00_0000, rd_byte};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_word : 32'h0000_0000;
            rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// ===== tb/mch_uart_cfg_checker.sv
// port assertions for the serial configuration block
`timescale 1ns/100ps
`include "mch_uart_consts.svh"
module mch_uart_cfg_checker
    import mch_uart_pkg::*;
#(
    parameter int BAUD_W = 16
)
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic [4:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read valid
    input wire logic s_axi_arready, // read ready
    input wire logic s_axi_rvalid, // data valid
    input wire logic mch_rx_busy, // rx running
    input wire frame_cfg_s frame_cfg, // frame setup
    input wire logic mch_bit_tick, // bit tick
    input wire logic rx_buf_read // buffer read
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_size_codes: assert property (frame_cfg.size_ok |->
        frame_cfg.rx_bits inside {[5:9], [13:17]} && frame_cfg.tx_bits inside {[5:9], [13:17]})
        else $error("size outside code set");
    a_dual_len_lvl: assert property (frame_cfg.rx_accept_16 &&
        frame_cfg.mode inside {MODE_EXT_ASYNC_LVL, MODE_EXT_SYNC_LVL} |-> !frame_cfg.size_ok)
        else $error("dual length accepted without Manchester");
    a_sync_mch_rsvd: assert property (frame_cfg.mode == MODE_RESERVED
        |-> !frame_cfg.size_ok) else $error("reserved mode accepted");
    a_std_upto_9: assert property (frame_cfg.mode inside {MODE_STD_ASYNC, MODE_STD_SYNC}
        |-> frame_cfg.rx_bits <= 9 && frame_cfg.tx_bits <= 9) else $error("standard over 9");
    a_mode_onehot: assert property ($onehot(frame_cfg.mode))
        else $error("mode not one-hot");
    a_tick_idle: assert property (!mch_rx_busy |-> !mch_bit_tick)
        else $error("tick outside reception");
    a_buf_read_src: assert property (rx_buf_read |->
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `A_RX_DATA) else $error("bad read pulse");
    a_buf_read_ans: assert property (rx_buf_read |=> s_axi_rvalid)
        else $error("buffer read without answer");
    a_buf_read_hit: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == `A_RX_DATA |-> rx_buf_read) else $error("data read not flagged");
endmodule

bind mch_uart_cfg mch_uart_cfg_checker #(.BAUD_W(BAUD_W)) u_mch_uart_cfg_checker (.aclk,
    .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mch_rx_busy,
    .frame_cfg, .mch_bit_tick, .rx_buf_read);

// ===== tb/mch_node.sv
// remote node model: reception window and frame-complete event
`timescale 1ns/100ps
module mch_node
    import mch_uart_pkg::*;
(
    output rx_evt_s rx_evt, // frame event
    output logic mch_rx_busy, // rx running
    input wire logic aclk // clock
);
    initial
    begin
        rx_evt = '0;
        mch_rx_busy = 1'b0;
    end
    // f is {framing error, 17 bits, stop bits}; lines scramble after the pulse
    task automatic send(input logic [3:0] f, input logic [16:0] d, input int n);
        @(posedge aclk);
        mch_rx_busy <= 1'b1;
        repeat (n) @(posedge aclk);
        mch_rx_busy <= 1'b0;
        rx_evt <= {1'b1, f, d};
        @(posedge aclk);
        rx_evt <= {1'b0, ~f, ~d};
        @(posedge aclk);
    endtask
endmodule

// ===== tb/extended_serial_manchester_config_tb.sv
// bench: registers, mode decode, receive status and bit timer
`timescale 1ns/100ps
module extended_serial_manchester_config_tb
    import mch_uart_pkg::*;
;
    logic aclk, aresetn, mch_rx_busy, mch_bit_tick, rx_buf_read;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    rx_evt_s rx_evt;
    frame_cfg_s frame_cfg;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int ticks = 0;
    // {addr, reset value, write value, read back}
    logic [31:0] regs [5] = '{32'h0033_ffff, 32'h0400_1b1b, 32'h0800_0f00, 32'h0c00_a5a5,
        32'h1000_5a5a};
    // {code, bits}
    logic [11:0] sizes [10] = '{12'h005, 12'h106, 12'h207, 12'h308, 12'h709, 12'h80d,
        12'h90e, 12'ha0f, 12'hb10, 12'hf11};
    // {ext ctrl, std ctrl, mode, size_ok rx2 tx2 msb}
    logic [31:0] modes [7] = '{32'h0060_0108, 32'h1b60_080d, 32'h1263_2002,
        32'h0263_020e, 32'h1060_0408, 32'h1061_1008, 32'h1862_040e};
    wire [3:0] flg = {frame_cfg.size_ok, frame_cfg.rx_two_stop, frame_cfg.tx_two_stop,
        frame_cfg.msb_first};

    mch_uart_cfg u_mch_uart_cfg (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_evt, .mch_rx_busy, .frame_cfg, .mch_bit_tick, .rx_buf_read);
    mch_node u_mch_node (.rx_evt, .mch_rx_busy, .aclk);

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wc(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'b1) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        chk({s_axi_rresp, s_axi_rdata}, {er, e});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (mch_bit_tick === 1'b1)
            ticks <= ticks + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk({frame_cfg.mode, frame_cfg.rx_bits}, {MODE_STD_ASYNC, 5'h05});
        for (int i = 0; i < 5; i++)
            rc(regs[i][28:24], regs[i][23:16], 2'b00);
        for (int i = 0; i < 5; i++)
        begin
            wc(regs[i][28:24], regs[i][15:8], 2'b00);
            rc(regs[i][28:24], regs[i][7:0], 2'b00);
        end
        note("registers");
        wc(5'h04, 8'h10, 2'b00);
        for (int i = 0; i < 10; i++)
        begin
            wc(5'h00, {2{sizes[i][11:8]}}, 2'b00);
            chk(frame_cfg.rx_bits, sizes[i][4:0]);
            chk(frame_cfg.tx_bits, sizes[i][4:0]);
        end
        wc(5'h00, 8'h44, 2'b00);
        chk(frame_cfg.size_ok, 1'b0);
        wc(5'h04, 8'h12, 2'b00);
        wc(5'h00, 8'hfe, 2'b00);
        chk({frame_cfg.rx_accept_16, frame_cfg.size_ok, frame_cfg.manchester}, 3'h7);
        wc(5'h00, 8'hee, 2'b00);
        chk(frame_cfg.size_ok, 1'b0);
        wc(5'h00, 8'hfe, 2'b00);
        wc(5'h04, 8'h10, 2'b00);
        chk({frame_cfg.size_ok, frame_cfg.manchester}, 2'h0);
        wc(5'h00, 8'hff, 2'b00);
        for (int i = 0; i < 7; i++)
        begin
            wc(5'h14, modes[i][23:16], 2'b00);
            wc(5'h04, modes[i][31:24], 2'b00);
            chk(frame_cfg.mode, modes[i][15:8]);
            chk(flg, modes[i][3:0]);
        end
        wc(5'h14, 8'h78, 2'b00);
        chk(frame_cfg.parity_sel, 2'h3);
        note("modes");
        wc(5'h14, 8'h60, 2'b00);
        wc(5'h00, 8'hfe, 2'b00);
        wc(5'h04, 8'h12, 2'b00);
        u_mch_node.send(4'b1110, 17'h1_2345, 6);
        rc(5'h08, 8'h0e, 2'b00);
        rc(5'h18, 32'h0001_2345, 2'b00);
        rc(5'h08, 8'h02, 2'b00);
        u_mch_node.send(4'b0001, 17'h0_0055, 6);
        rc(5'h08, 8'h01, 2'b00);
        wc(5'h04, 8'h10, 2'b00);
        u_mch_node.send(4'b1110, 17'h0_0001, 3);
        rc(5'h08, 8'h01, 2'b00);
        wc(5'h04, 8'h00, 2'b00);
        wc(5'h14, 8'he0, 2'b00);
        u_mch_node.send(4'b0000, 17'h0_0100, 3);
        rc(5'h18, 32'h0001_0000, 2'b00);
        wc(5'h04, 8'h10, 2'b00);
        wc(5'h00, 8'h77, 2'b00);
        u_mch_node.send(4'b0000, 17'h0_0100, 3);
        rc(5'h18, 32'h0000_0100, 2'b00);
        note("status");
        wc(5'h0c, 8'h03, 2'b00);
        wc(5'h10, 8'h00, 2'b00);
        wc(5'h04, 8'h12, 2'b00);
        ticks = 0;
        u_mch_node.send(4'b0000, 17'h0_0000, 40);
        chk(ticks, 10);
        wc(5'h10, 8'h01, 2'b00);
        ticks = 0;
        u_mch_node.send(4'b0000, 17'h0_0000, 40);
        chk(ticks, 0);
        note("timer");
        wc(5'h1c, 8'h00, 2'b10);
        rc(5'h1c, 32'h0, 2'b10);
        rc(5'h01, 32'h0, 2'b10);
        s_axi_wstrb <= 4'h0;
        wc(5'h0c, 8'hff, 2'b00);
        s_axi_wstrb <= 4'hf;
        rc(5'h0c, 8'h03, 2'b00);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(5'h00, 8'h33, 2'b00);
        rc(5'h04, 8'h00, 2'b00);
        note("reset");
        summarize();
    end
endmodule
